// ==== common/hcdg_pkg.sv ====
// constants for the hub class descriptor generator
package hcdg_pkg;
    // ==========================================
    // configuration register offsets
    localparam logic [7:0] ADDR_CONFIG_BYTE_ONE = 8'h06;
    localparam logic [7:0] ADDR_NONREMOVABLE = 8'h08;
    localparam logic [7:0] ADDR_DISABLED_SP = 8'h0A;
    localparam logic [7:0] ADDR_DISABLED_BP = 8'h0B;
    localparam logic [7:0] ADDR_CURRENT_SP = 8'h0E;
    localparam logic [7:0] ADDR_CURRENT_BP = 8'h0F;
    localparam logic [7:0] ADDR_POWER_ON_TIME = 8'h10;
    // ==========================================
    // config_byte_one field positions
    localparam int CONF_ONE_POWER_SOURCE_BIT = 7;
    localparam int CONF_ONE_COMPOUND_BIT = 3;
    localparam int CONF_ONE_SENSE_HI = 2;
    localparam int CONF_ONE_SENSE_LO = 1;
    localparam int CONF_ONE_PORT_POWER_BIT = 0;
    localparam logic [7:0] CONF_ONE_WRITE_MASK = 8'h8F;
    // disabled-port masks: bits 3:1 stand for ports 1 to 3
    localparam int PORT_MASK_HI = 3;
    localparam int PORT_MASK_LO = 1;
    localparam logic [7:0] PORT_MASK_WRITE = 8'h0E;
    // ==========================================
    // internal default load values
    localparam logic [7:0] DEF_CONFIG_BYTE_ONE = 8'h00;
    localparam logic [7:0] DEF_NONREMOVABLE = 8'h00;
    localparam logic [7:0] DEF_DISABLED_SP = 8'h00;
    localparam logic [7:0] DEF_DISABLED_BP = 8'h00;
    localparam logic [7:0] DEF_CURRENT_SP = 8'h01;
    localparam logic [7:0] DEF_CURRENT_BP = 8'h64;
    localparam logic [7:0] DEF_POWER_ON_TIME = 8'h32;
    // ==========================================
    // descriptor layout
    localparam logic [7:0] DESC_TYPE_HUB = 8'h29;
    localparam logic [7:0] DESC_TYPE_LEGACY = 8'h00;
    localparam logic [7:0] DESC_LENGTH = 8'h09;
    localparam logic [7:0] DESC_POWER_CTRL_MASK = 8'hFF;
    localparam logic [7:0] DESC_ZERO = 8'h00;
    localparam logic [1:0] PORTS_TOTAL = 2'h3;
    localparam logic [1:0] LOGICAL_PWR_GANGED = 2'h0;
    localparam logic [1:0] LOGICAL_PWR_PER_PORT = 2'h1;
    localparam logic [1:0] TT_THINK_8FS = 2'h0;
    localparam logic PORT_INDICATOR_NONE = 1'b0;
    localparam int IDX_LENGTH = 0;
    localparam int IDX_TYPE = 1;
    localparam int IDX_PORTS = 2;
    localparam int IDX_CHAR_LO = 3;
    localparam int IDX_CHAR_HI = 4;
    localparam int IDX_POWER_ON = 5;
    localparam int IDX_CURRENT = 6;
    localparam int IDX_REMOVABLE = 7;
    localparam int IDX_PWR_MASK = 8;
    localparam int DESC_BYTES = 9;
    localparam logic [3:0] IDX_FIRST = 4'h0;
    localparam logic [3:0] IDX_STEP = 4'h1;
    // ==========================================
    // transfer states
    typedef enum logic [0:0] {
        HCDG_IDLE = 1'b0,
        HCDG_SEND = 1'b1
    } hcdg_state_type;
endpackage

// ==== rtl/hcdg_cfg_regs.sv ====
// configuration register store loaded by defaults or the serial port
module hcdg_cfg_regs
    import hcdg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic [7:0] config_byte_one,
    output logic [7:0] nonremovable_port_mask,
    output logic [7:0] disabled_ports_selfpowered,
    output logic [7:0] disabled_ports_buspowered,
    output logic [7:0] ctrl_current_selfpowered,
    output logic [7:0] ctrl_current_buspowered,
    output logic [7:0] power_on_time
);
    // ==========================================
    // decode
    logic [7:0] conf_one_reg, nrem_reg, dsp_reg, dbp_reg, csp_reg, cbp_reg, pon_reg, rdata_reg;
    logic [7:0] rdata_next;
    wire sel_conf_one = cfg_addr == ADDR_CONFIG_BYTE_ONE;
    wire sel_nrem = cfg_addr == ADDR_NONREMOVABLE;
    wire sel_dsp = cfg_addr == ADDR_DISABLED_SP;
    wire sel_dbp = cfg_addr == ADDR_DISABLED_BP;
    wire sel_csp = cfg_addr == ADDR_CURRENT_SP;
    wire sel_cbp = cfg_addr == ADDR_CURRENT_BP;
    wire sel_pon = cfg_addr == ADDR_POWER_ON_TIME;
    // unmapped offsets read as zero
    assign rdata_next = sel_conf_one ? conf_one_reg : sel_nrem ? nrem_reg : sel_dsp ? dsp_reg :
        sel_dbp ? dbp_reg : sel_csp ? csp_reg : sel_cbp ? cbp_reg :
        sel_pon ? pon_reg : DESC_ZERO;
    // ==========================================
    // storage
    always_ff @(posedge clk) begin
        if (rst) begin
            // internal default load
            conf_one_reg <= DEF_CONFIG_BYTE_ONE;
            nrem_reg <= DEF_NONREMOVABLE;
            dsp_reg <= DEF_DISABLED_SP;
            dbp_reg <= DEF_DISABLED_BP;
            csp_reg <= DEF_CURRENT_SP;
            cbp_reg <= DEF_CURRENT_BP;
            pon_reg <= DEF_POWER_ON_TIME;
        end else if (cfg_wr_en) begin
            // serial port load; reserved bits stay zero
            if (sel_conf_one) conf_one_reg <= cfg_wdata & CONF_ONE_WRITE_MASK;
            if (sel_nrem) nrem_reg <= cfg_wdata;
            if (sel_dsp) dsp_reg <= cfg_wdata & PORT_MASK_WRITE;
            if (sel_dbp) dbp_reg <= cfg_wdata & PORT_MASK_WRITE;
            if (sel_csp) csp_reg <= cfg_wdata;
            if (sel_cbp) cbp_reg <= cfg_wdata;
            if (sel_pon) pon_reg <= cfg_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= DESC_ZERO;
        end else if (cfg_rd_en) begin
            rdata_reg <= rdata_next;
        end
    end
    assign cfg_rdata = rdata_reg;
    assign config_byte_one = conf_one_reg;
    assign nonremovable_port_mask = nrem_reg;
    assign disabled_ports_selfpowered = dsp_reg;
    assign disabled_ports_buspowered = dbp_reg;
    assign ctrl_current_selfpowered = csp_reg;
    assign ctrl_current_buspowered = cbp_reg;
    assign power_on_time = pon_reg;
endmodule

// ==== rtl/hcdg_top.sv ====
// hub class descriptor generator: config store and byte streamer
// Notes on behaviour
// - answer descriptor types 29h and legacy 00h
// - byte 0 is 09h, byte 1 is 29h
// - ports equal three minus disabled ports
// - power source bit picks disabled-port mask
// - characteristics come from default or serial load
// - D1:0 is 01b with per-port power
// - D2 compound, D4:3 overcurrent sense mode
// - D6:5 fixed zero, 8 FS think time
// - D7 zero, upper characteristics byte zero
// - power-on time byte passed through unchanged
// - controller current byte in 1 mA units
// - power source bit picks controller current
// - byte 7 is the nonremovable port mask
// - byte 8 is constant FFh
module hcdg_top
    import hcdg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic req_valid,
    input wire logic [7:0] req_type,
    input wire logic [15:0] req_length,
    output logic req_stall,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready
);
    // ==========================================
    // configuration store
    logic [7:0] config_byte_one;
    logic [7:0] nonremovable_port_mask;
    logic [7:0] disabled_ports_selfpowered;
    logic [7:0] disabled_ports_buspowered;
    logic [7:0] ctrl_current_selfpowered;
    logic [7:0] ctrl_current_buspowered;
    logic [7:0] power_on_time;

    hcdg_cfg_regs u_regs (
        .clk(clk),
        .rst(rst),
        .cfg_wr_en(cfg_wr_en),
        .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata),
        .config_byte_one(config_byte_one),
        .nonremovable_port_mask(nonremovable_port_mask),
        .disabled_ports_selfpowered(disabled_ports_selfpowered),
        .disabled_ports_buspowered(disabled_ports_buspowered),
        .ctrl_current_selfpowered(ctrl_current_selfpowered),
        .ctrl_current_buspowered(ctrl_current_buspowered),
        .power_on_time(power_on_time)
    );

    // ==========================================
    // descriptor field derivation
    wire power_source_select = config_byte_one[CONF_ONE_POWER_SOURCE_BIT];
    wire per_port_power_switching = config_byte_one[CONF_ONE_PORT_POWER_BIT];
    wire compound_device = config_byte_one[CONF_ONE_COMPOUND_BIT];
    wire [1:0] overcurrent_sense_mode = config_byte_one[CONF_ONE_SENSE_HI:CONF_ONE_SENSE_LO];
    // the mask follows the live power mode, so a mode change mid-answer shows in bytes loaded after it
    wire [2:0] disabled_mask = power_source_select ?
        disabled_ports_selfpowered[PORT_MASK_HI:PORT_MASK_LO] :
        disabled_ports_buspowered[PORT_MASK_HI:PORT_MASK_LO];
    wire [1:0] disabled_count = 2'(disabled_mask[0]) + 2'(disabled_mask[1]) +
        2'(disabled_mask[2]);
    wire [1:0] ports_enabled = PORTS_TOTAL - disabled_count;
    wire [1:0] logical_power = per_port_power_switching ?
        LOGICAL_PWR_PER_PORT : LOGICAL_PWR_GANGED;
    wire [7:0] char_low = {PORT_INDICATOR_NONE, TT_THINK_8FS, overcurrent_sense_mode,
        compound_device, logical_power};
    wire [7:0] ctrl_current = power_source_select ?
        ctrl_current_selfpowered : ctrl_current_buspowered;

    logic [7:0] desc_bytes [DESC_BYTES];
    assign desc_bytes[IDX_LENGTH] = DESC_LENGTH;
    assign desc_bytes[IDX_TYPE] = DESC_TYPE_HUB;
    assign desc_bytes[IDX_PORTS] = {6'h00, ports_enabled};
    assign desc_bytes[IDX_CHAR_LO] = char_low;
    assign desc_bytes[IDX_CHAR_HI] = DESC_ZERO;
    assign desc_bytes[IDX_POWER_ON] = power_on_time;
    assign desc_bytes[IDX_CURRENT] = ctrl_current;
    assign desc_bytes[IDX_REMOVABLE] = nonremovable_port_mask;
    assign desc_bytes[IDX_PWR_MASK] = DESC_POWER_CTRL_MASK;

    // ==========================================
    // request decode
    hcdg_state_type state_reg;
    hcdg_state_type state_next;
    logic [3:0] index_reg;
    logic [3:0] index_next;
    logic [3:0] count_reg;
    logic [3:0] count_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic valid_reg;
    logic valid_next;
    logic last_reg;
    logic last_next;
    logic stall_reg;
    logic stall_next;

    wire type_match = req_type == DESC_TYPE_HUB || req_type == DESC_TYPE_LEGACY;
    wire long_request = req_length >= 16'(DESC_BYTES);
    // truncate to the host's length, never beyond the descriptor
    wire [3:0] send_count = long_request ? 4'(DESC_BYTES) : req_length[3:0];
    wire start = state_reg == HCDG_IDLE && req_valid && type_match && send_count != 4'h0;
    wire [3:0] index_step = index_reg + IDX_STEP;
    wire [3:0] index_after = index_step + IDX_STEP;
    wire advance = state_reg == HCDG_SEND && tx_ready;

    // ==========================================
    // transfer sequencing
    always_comb begin
        state_next = state_reg;
        index_next = index_reg;
        count_next = count_reg;
        data_next = data_reg;
        valid_next = valid_reg;
        last_next = last_reg;
        // unknown descriptor types are stalled; requests during a send are ignored
        stall_next = state_reg == HCDG_IDLE && req_valid && !type_match;
        case (state_reg)
            HCDG_IDLE: begin
                if (start) begin
                    state_next = HCDG_SEND;
                    index_next = IDX_FIRST;
                    count_next = send_count;
                    data_next = desc_bytes[IDX_FIRST];
                    valid_next = 1'b1;
                    last_next = send_count == IDX_STEP;
                end
            end
            HCDG_SEND: begin
                if (advance) begin
                    if (last_reg) begin
                        state_next = HCDG_IDLE;
                        valid_next = 1'b0;
                        last_next = 1'b0;
                    end else begin
                        // ascending offsets, one byte per accepted beat
                        index_next = index_step;
                        data_next = desc_bytes[index_step];
                        last_next = index_after == count_reg;
                    end
                end
            end
            default: begin
                state_next = HCDG_IDLE;
                valid_next = 1'b0;
                last_next = 1'b0;
            end
        endcase
    end

    // ==========================================
    // registers, one per block so each reset value sits by its flop
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= HCDG_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            index_reg <= IDX_FIRST;
        end else begin
            index_reg <= index_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= IDX_FIRST;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_reg <= DESC_ZERO;
        end else begin
            data_reg <= data_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= last_next;
        end
    end

    // stall is high one cycle after each idle cycle with a bad-type request; the host side must latch it if needed
    always_ff @(posedge clk) begin
        if (rst) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= stall_next;
        end
    end

    assign tx_valid = valid_reg;
    assign tx_data = data_reg;
    assign tx_last = last_reg;
    assign req_stall = stall_reg;
endmodule

// ==== sim/hcdg_top_asserts.sv ====
// port checker for the hub class descriptor generator
module hcdg_top_asserts
    import hcdg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_rdata,
    input wire logic req_valid,
    input wire logic [7:0] req_type,
    input wire logic [15:0] req_length,
    input wire logic req_stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========
    // beat counter, cleared whenever the stream is idle
    logic [3:0] beat_reg;
    wire good_type = req_type == DESC_TYPE_HUB || req_type == DESC_TYPE_LEGACY;
    wire idle_req = !tx_valid && req_valid;
    always_ff @(posedge clk) begin
        if (rst || !tx_valid) beat_reg <= 4'h0;
        else if (tx_ready) beat_reg <= beat_reg + 4'h1;
    end
    sequence s_take_good;
        idle_req && good_type && req_length != 16'h0000;
    endsequence
    sequence s_first_taken;
        tx_valid && tx_ready && beat_reg == 4'h0 && !tx_last;
    endsequence
    property p_start;
        s_take_good |=> tx_valid && tx_data == DESC_LENGTH;
    endproperty
    a_start: assert property (p_start) else $error("no length byte");
    property p_stall;
        idle_req && !good_type |=> req_stall ##1 !req_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("bad type not refused");
    property p_zero;
        idle_req && req_length == 16'h0000 |=> !tx_valid;
    endproperty
    a_zero: assert property (p_zero) else $error("zero length sent");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
    property p_type_byte;
        s_first_taken |=> tx_valid && tx_data == DESC_TYPE_HUB;
    endproperty
    a_type_byte: assert property (p_type_byte) else $error("type byte wrong");
    property p_ports;
        tx_valid && beat_reg == 4'h2 |-> tx_data <= 8'h03;
    endproperty
    a_ports: assert property (p_ports) else $error("port count too big");
    property p_upper;
        tx_valid && beat_reg == 4'h4 |-> tx_data == DESC_ZERO;
    endproperty
    a_upper: assert property (p_upper) else $error("upper byte not zero");
    property p_mask;
        tx_valid && beat_reg == 4'h8 |-> tx_data == DESC_POWER_CTRL_MASK && tx_last;
    endproperty
    a_mask: assert property (p_mask) else $error("final byte wrong");
    property p_end;
        tx_valid && tx_ready && tx_last |=> !tx_valid;
    endproperty
    a_end: assert property (p_end) else $error("stream runs on");
    property p_rdata;
        !cfg_rd_en |=> $stable(cfg_rdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
bind hcdg_top hcdg_top_asserts i_chk (.clk(clk), .rst(rst), .cfg_rd_en(cfg_rd_en),
    .cfg_rdata(cfg_rdata), .req_valid(req_valid), .req_type(req_type),
    .req_length(req_length), .req_stall(req_stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

// ==== sim/hcdg_host_model.sv ====
// upstream host sink that paces byte acceptance
module hcdg_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    output logic tx_ready = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // slow mode refuses every other beat so held bytes get exercised
    always @(negedge clk) begin
        tx_ready <= !rst && (slow ? !tx_ready : 1'b1);
    end
endmodule

// ==== sim/test_hub_class_descriptor_gen.sv ====
// self-checking bench for the hub class descriptor generator
module test_hub_class_descriptor_gen
    import hcdg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, req_valid = 1'b0;
    logic slow = 1'b1, req_stall, tx_valid, tx_last, tx_ready;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, req_type = 8'h00, cfg_rdata, tx_data;
    logic [15:0] req_length = 16'h0000;
    logic [7:0] sh [0:255];
    logic [7:0] adr [0:6] = '{8'h06, 8'h08, 8'h0A, 8'h0B, 8'h0E, 8'h0F, 8'h10};
    logic [7:0] wv [0:6] = '{8'hFF, 8'h0E, 8'h06, 8'h09, 8'h3C, 8'hA5, 8'h7E};
    int failures = 0, num_checks = 0, cycles = 0;
    hcdg_top i_dut (.clk(clk), .rst(rst), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .req_valid(req_valid), .req_type(req_type), .req_length(req_length),
        .req_stall(req_stall), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));
    hcdg_host_model i_host (.clk(clk), .rst(rst), .slow(slow), .tx_ready(tx_ready));
    // ==========
    // tasks
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_wr_en = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr_en = 1'b0;
        // unmapped writes are dropped, reserved bits read back zero
        if (a inside {adr}) sh[a] = d & (a == ADDR_CONFIG_BYTE_ONE ? CONF_ONE_WRITE_MASK :
            (a == ADDR_DISABLED_SP || a == ADDR_DISABLED_BP) ? PORT_MASK_WRITE : 8'hFF);
    endtask
    task automatic cfg_read(input logic [7:0] a);
        @(negedge clk);
        cfg_rd_en = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd_en = 1'b0;
        check(cfg_rdata, sh[a]);
    endtask
    task automatic desc(input logic [7:0] t, input logic [15:0] len);
        logic [7:0] e [0:8];
        logic [7:0] c;
        logic [7:0] m;
        logic ok;
        int n;
        int k;
        c = sh[ADDR_CONFIG_BYTE_ONE];
        m = c[CONF_ONE_POWER_SOURCE_BIT] ? sh[ADDR_DISABLED_SP] : sh[ADDR_DISABLED_BP];
        e = '{DESC_LENGTH, DESC_TYPE_HUB, 8'h03 - 8'($countones(m[3:1])),
            {3'h0, c[2:1], c[3], 1'b0, c[0]}, DESC_ZERO, sh[ADDR_POWER_ON_TIME],
            c[CONF_ONE_POWER_SOURCE_BIT] ? sh[ADDR_CURRENT_SP] : sh[ADDR_CURRENT_BP],
            sh[ADDR_NONREMOVABLE], DESC_POWER_CTRL_MASK};
        ok = t inside {DESC_TYPE_HUB, DESC_TYPE_LEGACY};
        n = !ok ? 0 : (len > 9 ? 9 : int'(len));
        @(negedge clk);
        req_valid = 1'b1;
        req_type = t;
        req_length = len;
        @(negedge clk);
        req_valid = 1'b0;
        check({7'h0, req_stall}, {7'h0, !ok});
        for (k = 0; k < n; ) begin
            @(posedge clk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                check(tx_data, e[k]);
                check({7'h0, tx_last}, {7'h0, k == n - 1});
                k++;
            end
        end
        @(negedge clk);
        check({7'h0, tx_valid}, 8'h00);
    endtask
    // ==========
    // clock, timeout, sequence
    initial forever #50 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        for (int i = 0; i < 256; i++) sh[i] = 8'h00;
        sh[ADDR_CURRENT_SP] = DEF_CURRENT_SP;
        sh[ADDR_CURRENT_BP] = DEF_CURRENT_BP;
        sh[ADDR_POWER_ON_TIME] = DEF_POWER_ON_TIME;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 7; i++) cfg_read(adr[i]);
        cfg_read(8'h01);
        desc(DESC_TYPE_HUB, 16'h0009);
        for (int i = 0; i < 7; i++) cfg_write(adr[i], wv[i]);
        cfg_write(8'h01, 8'h5A);
        for (int i = 0; i < 7; i++) cfg_read(adr[i]);
        cfg_read(8'h01);
        desc(DESC_TYPE_LEGACY, 16'h0100);
        slow = 1'b0;
        cfg_write(ADDR_CONFIG_BYTE_ONE, 8'h0A);
        desc(DESC_TYPE_HUB, 16'h0009);
        desc(DESC_TYPE_HUB, 16'h0002);
        desc(DESC_TYPE_HUB, 16'h0000);
        desc(8'h06, 16'h0009);
        desc(DESC_TYPE_LEGACY, 16'h0001);
        complete_run();
    end
endmodule
